// ==== hdl/lce_defs.vh ====
// Constants for the line code violation counter access block
`ifndef LCE_DEFS_VH
`define LCE_DEFS_VH
// ==========================================
// Register offsets
`define LCE_ADDR_W 8
`define LCE_OFS_CHSEL 8'h8c
`define LCE_OFS_CTRL 8'h8d
`define LCE_OFS_WINDOW 8'h8e
`define LCE_OFS_PARTID 8'hfe
// ==========================================
// Control register fields
`define LCE_CTRL_RESET 8'h00
`define LCE_BIT_CLR_SEL 0
`define LCE_BIT_LATCH_SEL 1
`define LCE_BIT_BYTE_SEL 2
`define LCE_BIT_LATCH_ALL 3
`define LCE_BIT_CLR_ALL 4
`define LCE_CHSEL_W 4
`define LCE_CHSEL_NONE 4'h0
`define LCE_CHSEL_RESET 8'h00
// ==========================================
// Widths and counts
`define LCE_NUM_CH 8
`define LCE_CNT_W 16
`define LCE_CNT_ZERO 16'h0000
`define LCE_CNT_ONE 16'h0001
`define LCE_CNT_MAX 16'hffff
`define LCE_BYTE_ZERO 8'h00
`endif

// ==== hdl/lce_hold_mem.v ====
// Holding registers for the latched per-channel counts
`timescale 1ns/10ps
`default_nettype none
`include "lce_defs.vh"
module lce_hold_mem #(
  parameter NUM_CH = `LCE_NUM_CH,
  parameter CNT_W = `LCE_CNT_W
) (
  // Clock and reset
  input wire core_clk,
  input wire srst,
  // Latch side
  input wire [NUM_CH-1:0] latchEn,
  input wire [NUM_CH*CNT_W-1:0] liveCounts,
  // Read side
  input wire [2:0] readCh,
  output reg [CNT_W-1:0] readData
);
  reg [CNT_W-1:0] holdMem [0:NUM_CH-1];
  genvar g;
  // ==========================================
  // Latch each held value until its next update
  generate
    for (g = 0; g < NUM_CH; g = g + 1)
    begin : gHold
      always @(posedge core_clk)
      begin
        if (srst)
          holdMem[g] <= `LCE_CNT_ZERO;
        else if (latchEn[g])
          holdMem[g] <= liveCounts[g*CNT_W +: CNT_W];
      end
    end
  endgenerate
  // ==========================================
  // Registered read port
  always @(posedge core_clk)
  begin
    if (srst)
      readData <= `LCE_CNT_ZERO;
    else
      readData <= holdMem[readCh];
  end
endmodule // lce_hold_mem
`default_nettype wire

// ==== hdl/lce_counter_access.v ====
// Line code violation counters with host control and byte readout
`timescale 1ns/10ps
`default_nettype none
`include "lce_defs.vh"
module lce_counter_access #(
  parameter NUM_CH = `LCE_NUM_CH,
  parameter CNT_W = `LCE_CNT_W,
  // Arbitrary neutral value
  parameter [7:0] PART_ID = 8'h5a
) (
  // Clock and reset
  input wire core_clk,
  input wire srst,
  // Register port, same clock as the host logic
  input wire regWrite,
  input wire regRead,
  input wire [`LCE_ADDR_W-1:0] regAddr,
  input wire [7:0] regWdata,
  output reg [7:0] regRdata,
  output reg regRvalid,
  // Violation events from the line decoders, one per channel
  input wire [NUM_CH-1:0] lineCodeViolation
);
  reg [7:0] chanSelect_r;
  reg [7:0] counterCtrl_r;
  reg [NUM_CH-1:0] violSync1_r;
  reg [NUM_CH-1:0] violSync2_r;
  reg [NUM_CH*CNT_W-1:0] liveCount_r;
  reg [7:0] rdata_nxt;
  wire [`LCE_CHSEL_W-1:0] selCode;
  wire selValid;
  wire [2:0] selIdx;
  wire [`LCE_CHSEL_W-1:0] selMinusOne;
  wire [NUM_CH-1:0] selOneHot;
  wire [NUM_CH-1:0] latchEn;
  wire [CNT_W-1:0] heldCount;
  wire [7:0] heldByte;
  wire clearEvery;
  wire latchEvery;
  wire byteHigh;
  wire clearSel;
  wire latchSel;
  genvar g;

  // ==========================================
  // Channel decode
  assign selCode = chanSelect_r[`LCE_CHSEL_W-1:0];
  // Codes above eight name no channel either
  assign selValid = (selCode != `LCE_CHSEL_NONE) && (selCode <= NUM_CH);
  assign selMinusOne = selCode - 4'h1;
  assign selIdx = selValid ? selMinusOne[2:0] : 3'h0;
  assign clearEvery = counterCtrl_r[`LCE_BIT_CLR_ALL];
  assign latchEvery = counterCtrl_r[`LCE_BIT_LATCH_ALL];
  assign byteHigh = counterCtrl_r[`LCE_BIT_BYTE_SEL];
  assign latchSel = counterCtrl_r[`LCE_BIT_LATCH_SEL];
  assign clearSel = counterCtrl_r[`LCE_BIT_CLR_SEL];

  // ==========================================
  // Violation input synchronisers
  always @(posedge core_clk)
  begin
    if (srst)
    begin
      violSync1_r <= {NUM_CH{1'b0}};
      violSync2_r <= {NUM_CH{1'b0}};
    end
    else
    begin
      violSync1_r <= lineCodeViolation;
      violSync2_r <= violSync1_r;
    end
  end

  // ==========================================
  // Per-channel live counters
  // Level-sensitive: clear and latch act for as long as the bit is one,
  // so the bench host's two-cycle (200 ns) hold is more than enough.
  generate
    for (g = 0; g < NUM_CH; g = g + 1)
    begin : gCnt
      assign selOneHot[g] = selValid && (selIdx == g);
      assign latchEn[g] = latchEvery || (latchSel && selOneHot[g]);
      always @(posedge core_clk)
      begin
        if (srst)
          liveCount_r[g*CNT_W +: CNT_W] <= `LCE_CNT_ZERO;
        else if (clearEvery)
          liveCount_r[g*CNT_W +: CNT_W] <= `LCE_CNT_ZERO;
        else if (clearSel && selOneHot[g])
          liveCount_r[g*CNT_W +: CNT_W] <= `LCE_CNT_ZERO;
        // Saturate rather than wrap so a large count never looks small
        else if (violSync2_r[g] && (liveCount_r[g*CNT_W +: CNT_W] != `LCE_CNT_MAX))
          liveCount_r[g*CNT_W +: CNT_W] <= liveCount_r[g*CNT_W +: CNT_W] + `LCE_CNT_ONE;
      end
    end
  endgenerate

  lce_hold_mem #(
    .NUM_CH(NUM_CH),
    .CNT_W(CNT_W)
  ) uHold (
    .core_clk(core_clk),
    .srst(srst),
    .latchEn(latchEn),
    .liveCounts(liveCount_r),
    .readCh(selIdx),
    .readData(heldCount)
  );

  // ==========================================
  // Byte window
  assign heldByte = !selValid ? `LCE_BYTE_ZERO :
    (byteHigh ? heldCount[CNT_W-1 -: 8] : heldCount[7:0]);

  // ==========================================
  // Register writes
  always @(posedge core_clk)
  begin
    if (srst)
    begin
      chanSelect_r <= `LCE_CHSEL_RESET;
      counterCtrl_r <= `LCE_CTRL_RESET;
    end
    else if (regWrite)
    begin
      if (regAddr == `LCE_OFS_CHSEL)
        chanSelect_r <= regWdata;
      else if (regAddr == `LCE_OFS_CTRL)
        counterCtrl_r <= regWdata;
    end
  end

  // ==========================================
  // Register reads; the window and part id ignore writes
  always @*
  begin
    rdata_nxt = `LCE_BYTE_ZERO;
    if (regAddr == `LCE_OFS_CHSEL)
      rdata_nxt = chanSelect_r;
    else if (regAddr == `LCE_OFS_CTRL)
      rdata_nxt = counterCtrl_r;
    else if (regAddr == `LCE_OFS_WINDOW)
      rdata_nxt = heldByte;
    else if (regAddr == `LCE_OFS_PARTID)
      rdata_nxt = PART_ID;
  end

  always @(posedge core_clk)
  begin
    if (srst)
    begin
      regRdata <= `LCE_BYTE_ZERO;
      regRvalid <= 1'b0;
    end
    else
    begin
      regRvalid <= regRead;
      if (regRead)
        regRdata <= rdata_nxt;
    end
  end
endmodule // lce_counter_access
`default_nettype wire

// ==== test/lce_line_src.sv ====
// Violation event source in place of the line decoders
`timescale 1ns/10ps
`default_nettype none
module lce_line_src (
  // Clock
  input wire logic core_clk,
  // Events
  output var logic [7:0] viol
);
  initial viol = 8'h00;
  // Drives mask for n cycles, then drops it
  task automatic burst(input logic [7:0] m, input int n);
    repeat (n) @(negedge core_clk) viol = m;
    @(negedge core_clk) viol = 8'h00;
  endtask
endmodule // lce_line_src
`default_nettype wire

// ==== test/lce_counter_access_properties.sv ====
// Port-level properties of the counter access block
`timescale 1ns/10ps
`default_nettype none
module lce_counter_access_props #(
  parameter [7:0] PART_ID = 8'h5a
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic [7:0] regRdata,
  input wire logic regRvalid
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  a_read_answer: assert property (regRead |=> regRvalid) else $error("no read answer");
  a_answer_cause: assert property (regRvalid |-> $past(regRead)) else $error("stray answer");
  a_data_holds: assert property (!$past(regRead) |-> $stable(regRdata)) else $error("data moved");
  a_id_fixed: assert property (regRead && regAddr == 8'hfe |=> regRdata == PART_ID)
    else $error("bad part id");
  a_reset_quiet: assert property (disable iff (1'b0) srst |=> !regRvalid && regRdata == 8'h00)
    else $error("reset state");
  a_ctrl_store: assert property (
    regWrite && regAddr == 8'h8d ##1 !regWrite ##1 regRead && regAddr == 8'h8d
    |=> regRdata == $past(regWdata, 3)) else $error("ctrl lost");
  a_sel_store: assert property (
    regWrite && regAddr == 8'h8c ##1 !regWrite ##1 regRead && regAddr == 8'h8c
    |=> regRdata == $past(regWdata, 3)) else $error("select lost");
  a_none_zero: assert property (
    regWrite && regAddr == 8'h8c && regWdata[3:0] == 4'h0 ##1 !regWrite[*2]
    ##1 regRead && regAddr == 8'h8e |=> regRdata == 8'h00) else $error("none not zero");
endmodule // lce_counter_access_props
`default_nettype wire

// ==== test/tb_top.sv ====
// Self-checking bench for the counter access block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic core_clk, srst, regWrite, regRead;
  logic [7:0] regAddr, regWdata, regRdata, viol;
  logic regRvalid;
  int miscompares = 0, nTests = 0, cyc = 0, seed, i;
  logic [15:0] n [8];
  lce_line_src src (.core_clk(core_clk), .viol(viol));
  lce_counter_access dut_u (.core_clk(core_clk), .srst(srst), .regWrite(regWrite),
    .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
    .regRvalid(regRvalid), .lineCodeViolation(viol));
  initial
  begin
    core_clk = 0;
    forever #50 core_clk = ~core_clk;
  end
  // ==========
  // Host accesses, entered at a falling edge
  task automatic wr(input logic [7:0] a, d);
    @(negedge core_clk);
    regWrite = 1; regAddr = a; regWdata = d;
    @(negedge core_clk);
    regWrite = 0;
  endtask
  task automatic ck(input logic [7:0] a, e);
    logic [7:0] q;
    // Window follows registered holding memory
    if (a == 8'h8e) @(negedge core_clk);
    @(negedge core_clk);
    regRead = 1; regAddr = a;
    @(negedge core_clk);
    regRead = 0;
    @(negedge core_clk);
    q = regRdata;
    nTests++;
    if (q !== e)
    begin
      miscompares++;
      $display("wrong value reg %h expected %h seen %h", a, e, q);
    end
  endtask
  task automatic cnt(input int ch, input logic [15:0] e);
    wr(8'h8c, 8'(ch + 1));
    wr(8'h8d, 8'h00);
    ck(8'h8e, e[7:0]);
    wr(8'h8d, 8'h04);
    ck(8'h8e, e[15:8]);
  endtask
  task automatic settle_latch();
    repeat (4) @(negedge core_clk);
    wr(8'h8d, 8'h08);
    wr(8'h8d, 8'h00);
  endtask
  task automatic giveVerdict();
    $display("comparisons %0d mismatches %0d", nTests, miscompares);
    if (miscompares == 0 && nTests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      miscompares++;
      giveVerdict();
    end
  end
  initial
  begin
    seed = 52627;
    regWrite = 0; regRead = 0; regAddr = 8'h00; regWdata = 8'h00; srst = 1;
    repeat (12) @(negedge core_clk);
    srst = 0;
    ck(8'h8d, 8'h00);
    wr(8'h8c, 8'h00);
    ck(8'h8e, 8'h00);
    wr(8'h8d, 8'he0);
    ck(8'h8d, 8'he0);
    wr(8'hfe, 8'h00);
    ck(8'hfe, 8'h5a);
    $display("test reset and storage done");
    for (i = 0; i < 8; i++)
    begin
      n[i] = 16'($unsigned($random(seed)) % 400);
      src.burst(8'h01 << i, n[i]);
    end
    settle_latch();
    for (i = 0; i < 8; i++) cnt(i, n[i]);
    $display("test latch all done");
    src.burst(8'h18, 5);
    repeat (4) @(negedge core_clk);
    wr(8'h8c, 8'h04);
    wr(8'h8d, 8'h02);
    wr(8'h8d, 8'h01);
    cnt(3, n[3] + 16'h0005);
    cnt(4, n[4]);
    wr(8'h8c, 8'h00);
    wr(8'h8d, 8'h03);
    settle_latch();
    cnt(3, 16'h0000);
    cnt(4, n[4] + 16'h0005);
    $display("test selected channel done");
    src.burst(8'hff, 3);
    repeat (4) @(negedge core_clk);
    wr(8'h8d, 8'h10);
    settle_latch();
    for (i = 0; i < 8; i++) cnt(i, 16'h0000);
    $display("test clear all done");
    giveVerdict();
  end
endmodule // tb_top
bind lce_counter_access lce_counter_access_props #(.PART_ID(PART_ID)) chk_u (.core_clk(core_clk),
  .srst(srst), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
  .regWdata(regWdata), .regRdata(regRdata), .regRvalid(regRvalid));
`default_nettype wire
